/* hw/ascp_top.sv */
// serial configuration port with register map and mode controls
//
// Behaviour
// - sample data on rising serial clock while select low; ignore clock otherwise
// - commit shifted frame to addressed register on every 24th rising edge
// - trailing bits short of a whole frame are dropped, no register changes
// - several whole frames in one select-low period each act separately
// - works at any serial clock up to 20 MHz and any duty cycle
// - writing one to bit 0 of 06h restores defaults, bit self-clears
// - eight data bits follow the address, captured on rising edges
// - frame with read flag set performs readback and never writes
// - readback shifts the addressed register's eight bits out during data phase
// - each readback bit is launched after a falling serial clock edge
// - data output enable is low and data output held low whenever readback is not active
// - power-down by pin or register; register picks pin as global or standby
// - writing 80h to clock_filter_bypass bypasses the sampling clock filter
// - clock divider offers bypass, divide-by-2 and divide-by-4
// - a register write enables the front-end chopper
// - per-channel dither-disable bits, dither on by default
// - 06h bit0 write-only self-clearing reset, bit1 test pattern, reset zero
`timescale 1ns/1ps
`default_nettype none

module ascp_top
    import ascp_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_en,
    input wire logic power_down_pin,
    output logic global_power_down,
    output logic standby_mode,
    output logic clock_filter_bypass_bit,
    output logic [1:0] clock_divider_sel,
    output logic chopper_enable,
    output logic [1:0] dither_disable_per_channel,
    output logic test_pattern_enable
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic [4:0] reg_index(input logic [ADDR_BITS-1:0] addr);
        logic [4:0] idx;
        idx = IDX_NONE;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (REG_OFFSETS[i] == addr) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    ascp_core_t core_reg;
    ascp_core_t core_next;
    ascp_shift_t shift_reg;
    ascp_shift_t shift_next;
    ascp_held_t held_reg;
    ascp_held_t held_next;
    ascp_out_t out_reg;
    ascp_out_t out_next;
    logic [4:0] write_idx;
    logic [4:0] read_idx;
    logic [DATA_BITS-1:0] read_byte;
    logic [ADDR_BITS-1:0] write_addr;
    logic pin_active;

    ////////////////////////////////////////////////////////////////////////
    // serial clock domain: shift in, rising edge

    always_comb begin
        shift_next = shift_reg;
        held_next = held_reg;
        if (shift_reg.cnt == CNT_LAST) begin
            held_next.word = {shift_reg.shift, serial_data_in};
            held_next.tgl = ~held_reg.tgl;
            shift_next.cnt = 5'h00;
        end else begin
            shift_next.cnt = shift_reg.cnt + 5'h01;
            shift_next.shift = {shift_reg.shift[FRAME_BITS-3:0], serial_data_in};
        end
    end

    // select high clears the partial frame and freezes the shifter
    always_ff @(posedge serial_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(posedge serial_clk or posedge reset) begin
        if (reset) begin
            held_reg <= '0;
        end else begin
            held_reg <= held_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial clock domain: readback, falling edge

    // register contents only change on a write frame or reset, never during readback
    always_comb begin
        read_idx = reg_index(shift_reg.shift[ADDR_BITS-1:0]);
        read_byte = REG_RESET;
        if (read_idx != IDX_NONE) begin
            read_byte = core_reg.regs[read_idx];
        end
    end

    always_comb begin
        out_next = out_reg;
        if (shift_reg.cnt == CNT_ADDR_DONE && shift_reg.shift[HDR_RW_POS]) begin
            out_next.out = read_byte;
            out_next.oe = 1'b1;
        end else if (out_reg.oe && shift_reg.cnt > CNT_ADDR_DONE) begin
            out_next.out = {out_reg.out[DATA_BITS-2:0], 1'b0};
        end else begin
            out_next.out = '0;
            out_next.oe = 1'b0;
        end
    end

    always_ff @(negedge serial_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            out_reg <= '0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign serial_data_out = out_reg.out[DATA_BITS-1];
    assign serial_data_out_en = out_reg.oe;

    ////////////////////////////////////////////////////////////////////////
    // system clock domain: register map and modes

    assign write_addr = held_reg.word[ADDR_MSB:ADDR_LSB];

    always_comb begin
        core_next = core_reg;
        core_next.tgl_sync = {core_reg.tgl_sync[0], held_reg.tgl};
        core_next.tgl_seen = core_reg.tgl_sync[1];
        core_next.pdn_sync = {core_reg.pdn_sync[0], power_down_pin};
        write_idx = reg_index(write_addr);
        pin_active = core_reg.pdn_sync[1];
        if (core_reg.tgl_sync[1] != core_reg.tgl_seen && !held_reg.word[RW_POS]
                && write_idx != IDX_NONE) begin
            if (write_addr == OFS_SOFT_RESET) begin
                if (held_reg.word[SOFT_RESET_POS]) begin
                    core_next.regs = '0;
                end else begin
                    core_next.regs[write_idx] = held_reg.word[DATA_BITS-1:0]
                        & SOFT_RESET_KEEP;
                end
            end else begin
                core_next.regs[write_idx] = held_reg.word[DATA_BITS-1:0];
            end
        end
        core_next.global_pd = core_next.regs[reg_index(OFS_POWER)][PWR_GLOBAL_POS]
            | (pin_active & ~core_next.regs[reg_index(OFS_POWER)][PWR_PIN_STANDBY_POS]);
        core_next.standby = core_next.regs[reg_index(OFS_POWER)][PWR_STANDBY_POS]
            | (pin_active & core_next.regs[reg_index(OFS_POWER)][PWR_PIN_STANDBY_POS]);
        core_next.filt_bypass = core_next.regs[reg_index(OFS_CLK_FILT)][CLK_FILT_POS];
        core_next.clk_div = core_next.regs[reg_index(OFS_CLOCK_DIV)][DIV_LSB+:2];
        if (core_next.clk_div != DIV_BY_2 && core_next.clk_div != DIV_BY_4) begin
            core_next.clk_div = DIV_BYPASS;
        end
        core_next.chopper = core_next.regs[reg_index(OFS_CHOPPER)][CHOPPER_POS];
        core_next.dither_dis = {
            core_next.regs[reg_index(OFS_DITHER_B)][DITHER_DIS_POS],
            core_next.regs[reg_index(OFS_DITHER_A)][DITHER_DIS_POS]};
        core_next.test_pattern =
            core_next.regs[reg_index(OFS_SOFT_RESET)][TEST_PATTERN_POS];
        if (reset) begin
            core_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        core_reg <= core_next;
    end

    assign global_power_down = core_reg.global_pd;
    assign standby_mode = core_reg.standby;
    assign clock_filter_bypass_bit = core_reg.filt_bypass;
    assign clock_divider_sel = core_reg.clk_div;
    assign chopper_enable = core_reg.chopper;
    assign dither_disable_per_channel = core_reg.dither_dis;
    assign test_pattern_enable = core_reg.test_pattern;

endmodule // ascp_top

`default_nettype wire

/* hw/ascp_pkg.sv */
// constants and types for the serial configuration port
package ascp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLOCK_PERIOD_PS = 4000;
    localparam int RESET_PULSE_NS = 10;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS * 1000 + CLOCK_PERIOD_PS - 1)
        / CLOCK_PERIOD_PS;
    localparam int SERIAL_CLK_MAX_KHZ = 20000;

    ////////////////////////////////////////////////////////////////////////
    // frame layout
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 14;
    localparam int DATA_BITS = 8;
    localparam int RW_POS = 23;
    localparam int FIXED_POS = 22;
    localparam int ADDR_MSB = 21;
    localparam int ADDR_LSB = 8;
    localparam int HDR_RW_POS = 15;
    localparam logic [4:0] CNT_LAST = 5'h17;
    localparam logic [4:0] CNT_ADDR_DONE = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam int NUM_REGS = 25;
    localparam logic [4:0] IDX_NONE = 5'h1F;
    localparam logic [ADDR_BITS-1:0] REG_OFFSETS [NUM_REGS] = '{
        14'h0001, 14'h0003, 14'h0004, 14'h0005, 14'h0006, 14'h0007, 14'h0009,
        14'h000A, 14'h000B, 14'h000E, 14'h000F, 14'h0013, 14'h0015, 14'h0025,
        14'h0027, 14'h041D, 14'h0422, 14'h0434, 14'h0439, 14'h051D, 14'h0522,
        14'h0534, 14'h0539, 14'h0608, 14'h070A};
    localparam logic [DATA_BITS-1:0] REG_RESET = 8'h00;

    localparam logic [ADDR_BITS-1:0] OFS_SOFT_RESET = 14'h0006;
    localparam logic [ADDR_BITS-1:0] OFS_CLOCK_DIV = 14'h0004;
    localparam logic [ADDR_BITS-1:0] OFS_CHOPPER = 14'h0005;
    localparam logic [ADDR_BITS-1:0] OFS_POWER = 14'h0015;
    localparam logic [ADDR_BITS-1:0] OFS_DITHER_A = 14'h041D;
    localparam logic [ADDR_BITS-1:0] OFS_DITHER_B = 14'h051D;
    localparam logic [ADDR_BITS-1:0] OFS_CLK_FILT = 14'h070A;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int SOFT_RESET_POS = 0;
    localparam int TEST_PATTERN_POS = 1;
    localparam logic [DATA_BITS-1:0] SOFT_RESET_KEEP = 8'h02;
    localparam int PWR_GLOBAL_POS = 0;
    localparam int PWR_STANDBY_POS = 1;
    localparam int PWR_PIN_STANDBY_POS = 2;
    localparam int CLK_FILT_POS = 7;
    localparam int DIV_LSB = 0;
    localparam int CHOPPER_POS = 0;
    localparam int DITHER_DIS_POS = 1;
    localparam logic [1:0] DIV_BYPASS = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // state records
    typedef struct packed {
        logic [NUM_REGS-1:0][DATA_BITS-1:0] regs;
        logic [1:0] tgl_sync;
        logic tgl_seen;
        logic [1:0] pdn_sync;
        logic global_pd;
        logic standby;
        logic filt_bypass;
        logic [1:0] clk_div;
        logic chopper;
        logic [1:0] dither_dis;
        logic test_pattern;
    } ascp_core_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic [FRAME_BITS-2:0] shift;
    } ascp_shift_t;

    typedef struct packed {
        logic [FRAME_BITS-1:0] word;
        logic tgl;
    } ascp_held_t;

    typedef struct packed {
        logic [DATA_BITS-1:0] out;
        logic oe;
    } ascp_out_t;

endpackage

/* testbench/ascp_top_assertions.sv */
// pin-level assertions for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module ascp_top_checker
    import ascp_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_en,
    input wire logic power_down_pin,
    input wire logic global_power_down,
    input wire logic standby_mode,
    input wire logic clock_filter_bypass_bit,
    input wire logic [1:0] clock_divider_sel,
    input wire logic chopper_enable,
    input wire logic [1:0] dither_disable_per_channel,
    input wire logic test_pattern_enable
);
    ////////////////////////////////////////////////////////////
    // bit position within the frame
    logic [4:0] cnt_reg;
    logic rw_reg;
    always_ff @(posedge serial_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            cnt_reg <= 5'h00;
            rw_reg <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == CNT_LAST) ? 5'h00 : cnt_reg + 5'h01;
            if (cnt_reg == 5'h00) rw_reg <= serial_data_in;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_idle_off;
        @(posedge clock) disable iff (reset) serial_select_n |-> !serial_data_out_en;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("output on while idle");
    property p_out_low;
        @(posedge clock) disable iff (reset) !serial_data_out_en |-> !serial_data_out;
    endproperty
    a_out_low: assert property (p_out_low) else $error("data seen while off");
    property p_window;
        @(posedge serial_clk) disable iff (reset || serial_select_n)
            serial_data_out_en == (rw_reg && cnt_reg >= CNT_ADDR_DONE);
    endproperty
    a_window: assert property (p_window) else $error("output phase wrong");
    property p_len;
        @(posedge serial_clk) disable iff (reset || serial_select_n)
            $rose(serial_data_out_en) |-> serial_data_out_en [*8] ##1 !serial_data_out_en;
    endproperty
    a_len: assert property (p_len) else $error("output not eight bits");
    property p_launch;
        @(posedge clock) disable iff (reset)
            serial_clk && $past(serial_clk) |-> $stable(serial_data_out);
    endproperty
    a_launch: assert property (p_launch) else $error("data moved while clock high");
    property p_quiet;
        @(posedge clock) disable iff (reset) serial_select_n [*8] |-> $stable({chopper_enable,
            clock_filter_bypass_bit, clock_divider_sel, dither_disable_per_channel,
            test_pattern_enable});
    endproperty
    a_quiet: assert property (p_quiet) else $error("mode moved while idle");
    property p_pin;
        @(posedge clock) disable iff (reset)
            power_down_pin [*4] |=> global_power_down || standby_mode;
    endproperty
    a_pin: assert property (p_pin) else $error("pin ignored");
    property p_div;
        @(posedge clock) disable iff (reset) clock_divider_sel != 2'h3;
    endproperty
    a_div: assert property (p_div) else $error("bad divider code");
endmodule // ascp_top_checker
`default_nettype wire

/* testbench/ascp_ctrl_model.sv */
// controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module ascp_ctrl_model (
    input wire logic clock,
    input wire logic sdo_line,
    output logic serial_clk,
    output logic serial_select_n,
    output logic serial_data_in
);
    initial {serial_clk, serial_select_n, serial_data_in} = 3'b010;
    // n bits msb first, clock low outside frames
    task automatic frame(input logic [47:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clock);
        #0.7 serial_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in = w[i];
            #50 serial_clk = 1'b1;
            if (i % 24 < 8) rd = {rd[6:0], sdo_line};
            #30 serial_clk = 1'b0;
        end
        #50 serial_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask
endmodule // ascp_ctrl_model
`default_nettype wire

/* testbench/testbench.sv */
// top testbench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ascp_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic power_down_pin = 1'b0;
    wire logic serial_clk, serial_select_n, serial_data_in, serial_data_out, serial_data_out_en;
    wire logic global_power_down, standby_mode, clock_filter_bypass_bit, chopper_enable;
    wire logic test_pattern_enable;
    wire logic [1:0] clock_divider_sel, dither_disable_per_channel;
    wire logic sdo_line = serial_data_out_en ? serial_data_out : 1'bz;
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] r;
    initial forever #2 clock = ~clock;
    ascp_top uut (.*);
    ascp_ctrl_model ctl (.*);
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        ctl.frame({24'h0, 2'b01, a, d}, 24, r);
    endtask
    task automatic rd(input logic [13:0] a, input logic [7:0] e);
        ctl.frame({24'h0, 2'b11, a, 8'h00}, 24, r);
        chk("readback", e, r);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clock);
        reset = 1'b0;
        repeat (3) @(negedge clock);
        for (int i = 0; i < NUM_REGS; i++) begin
            if (REG_OFFSETS[i] == OFS_SOFT_RESET) continue;
            rd(REG_OFFSETS[i], REG_RESET);
            wr(REG_OFFSETS[i], 8'hA0 + 8'(i));
            rd(REG_OFFSETS[i], 8'hA0 + 8'(i));
        end
        chk("loaded modes", 8'h2F, {2'h0, clock_divider_sel, chopper_enable,
            clock_filter_bypass_bit, dither_disable_per_channel});
        wr(OFS_SOFT_RESET, 8'h01);
        chk("cleared modes", 8'h00, {2'h0, clock_divider_sel, chopper_enable,
            clock_filter_bypass_bit, dither_disable_per_channel});
        rd(OFS_SOFT_RESET, 8'h00);
        rd(OFS_CLK_FILT, 8'h00);
        chk("chopper", 8'h00, {7'h0, chopper_enable});
        wr(OFS_SOFT_RESET, 8'h02);
        wr(OFS_CHOPPER, 8'h01);
        wr(OFS_CLK_FILT, 8'h80);
        wr(OFS_DITHER_B, 8'h02);
        rd(OFS_SOFT_RESET, 8'h02);
        chk("modes", 8'h1E, {3'h0, test_pattern_enable, chopper_enable,
            clock_filter_bypass_bit, dither_disable_per_channel});
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CLOCK_DIV, 8'(k));
            chk("divider", (k == 3) ? 8'h00 : 8'(k), {6'h0, clock_divider_sel});
        end
        ctl.frame({24'h0, 2'b11, OFS_CHOPPER, 8'hFE}, 24, r);
        rd(OFS_CHOPPER, 8'h01);
        wr(OFS_CHOPPER, 8'h00);
        chk("chopper", 8'h00, {7'h0, chopper_enable});
        ctl.frame({2'b01, 14'h0001, 8'h3C, 2'b11, 14'h0001, 8'h00}, 48, r);
        chk("back to back", 8'h3C, r);
        ctl.frame({18'h0, 2'b01, 14'h0003, 8'h5A, 6'h10}, 30, r);
        rd(14'h0003, 8'h5A);
        ctl.frame({36'h0, 12'hFFF}, 12, r);
        wr(14'h0009, 8'h66);
        rd(14'h0009, 8'h66);
        wr(14'h0002, 8'h77);
        rd(14'h0002, 8'h00);
        @(negedge clock);
        power_down_pin = 1'b1;
        repeat (5) @(negedge clock);
        chk("power", 8'h01, {6'h0, standby_mode, global_power_down});
        wr(OFS_POWER, 8'h04);
        chk("power", 8'h02, {6'h0, standby_mode, global_power_down});
        @(negedge clock);
        power_down_pin = 1'b0;
        wr(OFS_POWER, 8'h03);
        chk("power", 8'h03, {6'h0, standby_mode, global_power_down});
        summarize();
    end
endmodule // testbench
bind ascp_top ascp_top_checker chk_i (.*);
`default_nettype wire
